/* core/channel_clock_divider_delay_cfg.sv */
// One distribution channel: configuration registers, divider, delay, output gating.
// Assumes the byte register port is driven on sys_clk by the configuration logic.
//
// Contract
// - Divide codes 000 bypass, 010..110 give 4,6,8,12,16.
// - Channel power-down bit stops whole channel.
// - Output power-down bit stops that output.
// - Phase delay is value times input period.
// - Output drives only when enabled, else low.
module channel_clock_divider_delay_cfg
  import chan_cfg_pkg::*;
#(
  parameter int NUM_OUT = 3
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire cfg_req_t cfg_req,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  // Channel outputs
  output logic [NUM_OUT-1:0] channel_clock_output,
  output logic [NUM_OUT-1:0] output_active,
  output logic channel_active,
  output logic divider_init_exclude
);

  // ==========================================================================
  // Registers
  chan_cfg_t cfg_r;
  logic [NUM_OUT-1:0] out_pd_r;
  logic [NUM_OUT-1:0] out_en_r;
  logic init_excl_r;
  logic restart_r;

  // ==========================================================================
  // Address decode
  wire wr = cfg_req.we;
  wire hit_div = (cfg_req.addr == OFS_DIVIDE);
  wire hit_phase = (cfg_req.addr == OFS_PHASE);
  wire hit_ch_pd = (cfg_req.addr == OFS_CH_POWER);
  wire hit_init = (cfg_req.addr == OFS_INIT_CTRL);
  wire hit_en = (cfg_req.addr == OFS_OUT_ENABLE);
  logic [NUM_OUT-1:0] hit_out;
  logic [NUM_OUT-1:0] en_wbits;
  logic [NUM_OUT-1:0] pd_rbits;
  logic [7:0] en_rbyte;

  always_comb begin
    en_rbyte = 8'h00;
    for (int i = 0; i < NUM_OUT; i++) begin
      hit_out[i] = (cfg_req.addr == OFS_OUT_POWER0 + 8'(i));
      en_wbits[i] = cfg_req.wdata[EN_MSB_BIT - i];
      pd_rbits[i] = hit_out[i] & out_pd_r[i];
      en_rbyte[EN_MSB_BIT - i] = out_en_r[i];
    end
  end

  // ==========================================================================
  // Read answer
  // Reserved bits read as zero; unmapped addresses read zero.
  wire [7:0] rd_div = {5'h00, cfg_r.div_code};
  wire [7:0] rd_phase = cfg_r.phase;
  wire [7:0] rd_ch_pd = {cfg_r.ch_pd, 7'h00};
  wire [7:0] rd_init = {7'h00, init_excl_r};
  wire [7:0] rd_out = {|pd_rbits, 7'h00};
  wire [7:0] rd_mux =
      hit_div ? rd_div :
      hit_phase ? rd_phase :
      hit_ch_pd ? rd_ch_pd :
      hit_init ? rd_init :
      hit_en ? en_rbyte :
      (|hit_out) ? rd_out : 8'h00;
  // A read and a write in one cycle answer with the value before the write.
  wire [7:0] rdata_nxt = cfg_req.re ? rd_mux : 8'h00;
  wire rvalid_nxt = cfg_req.re;

  // ==========================================================================
  // Write strobes
  // Each register has its own strobe so a write touches exactly one field.
  wire wr_div = wr & hit_div;
  wire wr_phase = wr & hit_phase;
  wire wr_ch_pd = wr & hit_ch_pd;
  wire wr_init = wr & hit_init;
  wire wr_en = wr & hit_en;
  wire [NUM_OUT-1:0] wr_out = {NUM_OUT{wr}} & hit_out;
  wire cfg_change = wr_div | wr_phase | wr_ch_pd;

  // ==========================================================================
  // Register writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_r.div_code <= DIV_RESET;
      cfg_r.phase <= PHASE_RESET;
      cfg_r.ch_pd <= CH_PD_RESET;
    end else begin
      if (wr_div) begin
        cfg_r.div_code <= cfg_req.wdata[DIV_LSB +: DIV_W];
      end
      if (wr_phase) begin
        cfg_r.phase <= cfg_req.wdata;
      end
      if (wr_ch_pd) begin
        cfg_r.ch_pd <= cfg_req.wdata[CH_PD_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      init_excl_r <= INIT_EXCL_RESET;
    end else if (wr_init) begin
      init_excl_r <= cfg_req.wdata[INIT_EXCL_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      restart_r <= 1'b0;
    end else begin
      restart_r <= cfg_change;
    end
  end

  // Enable and output power-down writes leave the divider phase alone.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_pd_r <= {NUM_OUT{OUT_PD_RESET}};
    end else begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (wr_out[i]) out_pd_r[i] <= cfg_req.wdata[OUT_PD_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_en_r <= {NUM_OUT{EN_RESET}};
    end else if (wr_en) begin
      out_en_r <= en_wbits;
    end
  end

  // ==========================================================================
  // Divider and delay
  // Writes to the divide, phase or channel power register restart the phase so outputs stay aligned.
  // Code 111 maps to ratio zero, which parks the divider with no edges.
  wire [RATIO_W-1:0] ratio = div_ratio(cfg_r.div_code);
  wire chan_run = ~cfg_r.ch_pd;
  logic tick;

  chan_divider u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(chan_run),
    .restart(restart_r),
    .ratio(ratio),
    .delay(cfg_r.phase),
    .tick(tick)
  );

  // ==========================================================================
  // Output gating and read answer
  // Disabled or powered-down outputs are held low, never left floating.
  wire [NUM_OUT-1:0] out_on = ~out_pd_r & {NUM_OUT{chan_run}};
  wire [NUM_OUT-1:0] clk_nxt = {NUM_OUT{tick}} & out_on & out_en_r;

  // Every output is its own flop so decode glitches never reach a pin.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      channel_clock_output <= '0;
    end else begin
      channel_clock_output <= clk_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      output_active <= '0;
    end else begin
      output_active <= out_on;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      channel_active <= 1'b0;
    end else begin
      channel_active <= chan_run;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      divider_init_exclude <= 1'b0;
    end else begin
      divider_init_exclude <= init_excl_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_rdata <= 8'h00;
    end else begin
      cfg_rdata <= rdata_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= rvalid_nxt;
    end
  end

endmodule

/* core/chan_cfg_pkg.sv */
// Package for the channel clock divider and delay configuration block.
// Assumes a byte-wide register port on the distributed input clock.
package chan_cfg_pkg;

  // ==========================================================================
  // Register offsets of one channel
  localparam logic [7:0] OFS_DIVIDE = 8'h20;
  localparam logic [7:0] OFS_PHASE = 8'h21;
  localparam logic [7:0] OFS_CH_POWER = 8'h22;
  localparam logic [7:0] OFS_OUT_POWER0 = 8'h24;
  localparam logic [7:0] OFS_INIT_CTRL = 8'h71;
  localparam logic [7:0] OFS_OUT_ENABLE = 8'h74;

  // ==========================================================================
  // Field positions
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 3;
  localparam int CH_PD_BIT = 7;
  localparam int OUT_PD_BIT = 7;
  localparam int INIT_EXCL_BIT = 0;
  localparam int EN_MSB_BIT = 7;

  // ==========================================================================
  // Reset values
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic [7:0] PHASE_RESET = 8'h00;
  localparam logic CH_PD_RESET = 1'b0;
  localparam logic OUT_PD_RESET = 1'b0;
  localparam logic EN_RESET = 1'b0;
  localparam logic INIT_EXCL_RESET = 1'b0;

  // ==========================================================================
  // Divide codes and ratios
  localparam logic [2:0] DIV_BYPASS = 3'h0;
  localparam logic [2:0] DIV_UNDEF = 3'h7;
  localparam int RATIO_W = 5;

  typedef struct packed {
    logic [2:0] div_code;
    logic [7:0] phase;
    logic ch_pd;
  } chan_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } cfg_req_t;

  function automatic logic [RATIO_W-1:0] div_ratio(input logic [2:0] code);
    logic [RATIO_W-1:0] r;
    r = 5'h00;
    unique case (code)
      3'h0: r = 5'h01;
      3'h1: r = 5'h02;
      3'h2: r = 5'h04;
      3'h3: r = 5'h06;
      3'h4: r = 5'h08;
      3'h5: r = 5'h0C;
      3'h6: r = 5'h10;
      3'h7: r = 5'h00;
    endcase
    return r;
  endfunction

endpackage

/* core/chan_divider.sv */
// Divider and phase delay engine of one channel.
// Assumes ratio and delay are stable while run is high; restart reloads them.
module chan_divider
  import chan_cfg_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic [RATIO_W-1:0] ratio,
  input wire logic [7:0] delay,
  // Channel clock enable pulse
  output logic tick
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN = 2'b10
  } div_state_t;

  div_state_t state_r, state_nxt;
  logic [7:0] delay_cnt_r, delay_cnt_nxt;
  logic [RATIO_W-1:0] div_cnt_r, div_cnt_nxt;
  logic tick_nxt;

  // ==========================================================================
  // Sequencing
  wire delay_done = (delay_cnt_r == delay);
  wire div_last = (div_cnt_r == ratio - 5'h01);
  wire ratio_ok = (ratio != 5'h00);

  always_comb begin
    state_nxt = state_r;
    delay_cnt_nxt = delay_cnt_r;
    div_cnt_nxt = div_cnt_r;
    tick_nxt = 1'b0;
    if (!run || restart || !ratio_ok) begin
      state_nxt = (run && ratio_ok) ? ST_DELAY : ST_IDLE;
      delay_cnt_nxt = 8'h00;
      div_cnt_nxt = '0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          state_nxt = ST_DELAY;
        end
        ST_DELAY: begin
          // Whole input periods elapse before the first edge.
          if (delay_done) begin
            state_nxt = ST_RUN;
            tick_nxt = 1'b1;
            div_cnt_nxt = (ratio == 5'h01) ? '0 : 5'h01;
          end else begin
            delay_cnt_nxt = delay_cnt_r + 8'h01;
          end
        end
        ST_RUN: begin
          // Bypass ticks every cycle; others once per ratio cycles.
          tick_nxt = (div_cnt_r == '0);
          div_cnt_nxt = div_last ? '0 : div_cnt_r + 5'h01;
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      delay_cnt_r <= 8'h00;
      div_cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      state_r <= state_nxt;
      delay_cnt_r <= delay_cnt_nxt;
      div_cnt_r <= div_cnt_nxt;
      tick <= tick_nxt;
    end
  end

endmodule

/* verif/chan_cfg_monitor.sv */
// Checker for the channel configuration block.
// Assumes it is bound to the block's top module and sees its ports only.
module chan_cfg_monitor
  import chan_cfg_pkg::*;
#(
  parameter int NUM_OUT = 3
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire cfg_req_t cfg_req,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rvalid,
  // Channel outputs
  input wire logic [NUM_OUT-1:0] channel_clock_output,
  input wire logic [NUM_OUT-1:0] output_active,
  input wire logic channel_active,
  input wire logic divider_init_exclude
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire wr_en = cfg_req.we && cfg_req.addr == OFS_OUT_ENABLE;

  // ==========================================================================
  // Assertions
  a_read_answer: assert property (cfg_req.re |=> cfg_rvalid) else $error("read not answered");
  a_rdata_idle: assert property (!cfg_rvalid |-> cfg_rdata == 8'h00) else $error("read data not idle");
  a_chpd_write: assert property (cfg_req.we && cfg_req.addr == OFS_CH_POWER && cfg_req.wdata[CH_PD_BIT]
    |=> ##1 !channel_active) else $error("channel stayed up");
  a_chan_gates: assert property (!channel_active |-> output_active == '0) else $error("output up");
  a_chan_quiet: assert property (!channel_active [*2] |-> channel_clock_output == '0)
    else $error("clock while channel down");
  a_out_quiet: assert property (!output_active[0] [*2] |-> !channel_clock_output[0])
    else $error("clock while output down");
  a_enable_off: assert property (wr_en && !cfg_req.wdata[EN_MSB_BIT] ##1 !wr_en
    |=> !channel_clock_output[0]) else $error("disabled output drives");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> channel_clock_output == '0 && !cfg_rvalid)
    else $error("activity in reset");
  a_excl_copy: assert property (cfg_req.we && cfg_req.addr == OFS_INIT_CTRL
    |=> ##1 divider_init_exclude == $past(cfg_req.wdata[INIT_EXCL_BIT], 2)) else $error("exclude flag wrong");

  // ==========================================================================
  // Coverage
  c_read: cover property (cfg_rvalid);
  c_chan_down: cover property ($fell(channel_active));
  c_all_high: cover property (channel_clock_output == '1 [*3]);
endmodule

bind channel_clock_divider_delay_cfg chan_cfg_monitor #(.NUM_OUT(NUM_OUT)) mon (.sys_clk(sys_clk), .rst(rst),
  .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .channel_clock_output(channel_clock_output),
  .output_active(output_active), .channel_active(channel_active), .divider_init_exclude(divider_init_exclude));

/* verif/channel_clock_divider_delay_cfg_tb.sv */
// Testbench for the channel configuration block.
// Assumes the package and design are compiled first; drives the register port itself.
module channel_clock_divider_delay_cfg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import chan_cfg_pkg::*;
  typedef struct {logic [2:0] code; int ratio;} row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  cfg_req_t cfg_req = '0;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  logic [2:0] clk_out;
  logic [2:0] out_act;
  logic ch_act;
  logic excl;
  int error_cnt = 0;
  int num_checks = 0;
  int t0;
  int t1;
  int n;
  row_t rows[7] = '{'{3'h0, 1}, '{3'h1, 2}, '{3'h2, 4}, '{3'h3, 6}, '{3'h4, 8}, '{3'h5, 12}, '{3'h6, 16}};

  always #4 sys_clk = ~sys_clk;

  channel_clock_divider_delay_cfg uut (.sys_clk(sys_clk), .rst(rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .channel_clock_output(clk_out), .output_active(out_act), .channel_active(ch_act),
    .divider_init_exclude(excl));

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // The strobe drops for one edge after each access, so back-to-back calls never retoggle it at once.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    cfg_req = '{a, v, 1'b1, 1'b0};
    cyc(1);
    cfg_req.we = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    cfg_req = '{a, 8'h00, 1'b0, 1'b1};
    cyc(1);
    cfg_req.re = 1'b0;
    chk({7'h00, cfg_rvalid}, 8'h01);
    chk(cfg_rdata, v);
    cyc(1);
  endtask

  task automatic wait_tick(input int lim, output int t);
    t = 0;
    while (clk_out[0] !== 1'b1) begin
      cyc(1);
      t++;
      if (t > lim) begin
        error_cnt++;
        $display("MISMATCH %0t no clock pulse", $time);
        give_verdict();
      end
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    cyc(16);
    rst = 1'b0;
    chk({5'h00, clk_out}, 8'h00);
    rd(OFS_DIVIDE, 8'h00);
    rd(OFS_PHASE, 8'h00);
    rd(OFS_CH_POWER, 8'h00);
    rd(OFS_OUT_POWER0, 8'h00);
    rd(OFS_OUT_ENABLE, 8'h00);
    rd(OFS_INIT_CTRL, 8'h00);
    $display("test reset done");
    wr(OFS_OUT_ENABLE, 8'hE0);
    foreach (rows[i]) begin
      wr(OFS_DIVIDE, {5'h00, rows[i].code});
      rd(OFS_DIVIDE, {5'h00, rows[i].code});
      cyc(3);
      wait_tick(600, n);
      cyc(1);
      wait_tick(40, n);
      chk(8'(n + 1), 8'(rows[i].ratio));
    end
    wr(OFS_DIVIDE, 8'h07);
    cyc(4);
    n = 0;
    repeat (40) begin
      n += (clk_out[0] === 1'b1);
      cyc(1);
    end
    chk(8'(n), 8'h00);
    $display("test divide done");
    wr(OFS_DIVIDE, 8'h06);
    wr(OFS_PHASE, 8'h08);
    cyc(4);
    wait_tick(600, t0);
    wr(OFS_PHASE, 8'hFF);
    cyc(4);
    wait_tick(600, t1);
    chk(8'(t1 - t0), 8'(247));
    rd(OFS_PHASE, 8'hFF);
    $display("test phase done");
    wr(OFS_PHASE, 8'h00);
    wr(OFS_DIVIDE, 8'h00);
    wr(OFS_INIT_CTRL, 8'h01);
    cyc(4);
    chk({4'h0, excl, clk_out}, 8'h0F);
    wr(OFS_OUT_POWER0 + 8'h01, 8'hFF);
    cyc(2);
    chk({1'b0, out_act, 1'b0, clk_out}, 8'h55);
    rd(OFS_OUT_POWER0 + 8'h01, 8'h80);
    wr(OFS_CH_POWER, 8'h80);
    cyc(2);
    chk({1'b0, ch_act, out_act, clk_out}, 8'h00);
    rd(OFS_CH_POWER, 8'h80);
    wr(OFS_CH_POWER, 8'h00);
    wr(OFS_OUT_ENABLE, 8'h80);
    cyc(4);
    chk({4'h0, ch_act, clk_out}, 8'h09);
    wr(OFS_OUT_ENABLE, 8'h00);
    cyc(2);
    chk({5'h00, clk_out}, 8'h00);
    wr(8'h23, 8'hFF);
    rd(8'h23, 8'h00);
    $display("test power and enable done");
    wr(OFS_PHASE, 8'h33);
    wr(OFS_OUT_POWER0, 8'h80);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    rd(OFS_PHASE, 8'h00);
    rd(OFS_OUT_POWER0, 8'h00);
    chk({4'h0, excl, out_act}, 8'h07);
    $display("test mid reset done");
    give_verdict();
  end
endmodule
